/* File: rtl/dcp_cke_state.sv */
// ddr3 device side command and cke power state logic with dll-off timing
//
// Behaviour
// - commands decode from cs, ras, cas, we and cke at the rising edge
// - reset input asserts asynchronously and releases through two flops; controller keeps it high in use
// - bank address picks the bank, or the mode register on mode set
// - bursts always finish; burst length is fixed at four clocks, not read from the mode register
// - no refresh happens in power-down; controller keeps the refresh interval
// - termination input never steers state; termination off in self-refresh
// - self-refresh exit is seen asynchronously, without a running clock
// - nop and deselect register nothing and leave bursts running
// - cke fall enters power-down, rise exits; only nop or deselect then
// - refresh with cke falling enters self-refresh, only from all banks idle
// - power-down entry picks precharge or active by banks closed at completion
// - idle means banks closed, no burst, cke high
// - mode register 1 bit a0 disables the dll; clearing re-enables it
// - dll-off mode supports only read latency 6 with write latency 6
// - dll-off read window opens al plus cl minus one cycles after read
// - dll-off shifts only clock-to-strobe delay, not strobe-to-data skew
// - command and address are don't care in self-refresh and power-down
`timescale 1ns/1ps
`default_nettype none
module dcp_cke_state (
  input  wire logic                      i_core_clk,   // core clock, 50 MHz
  input  wire logic                      i_arst_n,     // async reset, active low
  input  wire logic                      i_cke,        // clock enable pin
  input  wire logic                      i_cs_n,       // chip select, active low
  input  wire logic                      i_ras_n,      // row strobe, active low
  input  wire logic                      i_cas_n,      // column strobe, active low
  input  wire logic                      i_we_n,       // write enable, active low
  input  wire logic [dcp_pkg::BA_W-1:0]  i_ba,         // bank address
  input  wire logic [dcp_pkg::ADDR_W-1:0] i_addr,      // address
  input  wire logic                      i_odt,        // on-die termination request
  input  wire logic [4:0]                i_cl,         // cas latency from mode register 0
  input  wire logic [4:0]                i_cwl,        // cas write latency from mode register 2
  input  wire logic [4:0]                i_al,         // additive latency from mode register 1
  output logic [2:0]                     o_state,      // power state code
  output logic [dcp_pkg::NBANK-1:0]      o_bank_open,  // open bank map
  output logic                           o_burst,      // burst in progress
  output logic                           o_idle,       // all banks idle, cke high
  output logic                           o_dll_off,    // dll disabled
  output logic                           o_lat_ok,     // latency legal for dll mode
  output logic                           o_odt_en,     // termination enabled
  output logic                           o_rd_window,  // read strobe window opens
  output logic                           o_cmd_valid,  // a command was registered
  output logic [3:0]                     o_cmd,        // registered command code
  output logic [dcp_pkg::BA_W-1:0]       o_cmd_ba,     // bank or mode register of it
  output logic [dcp_pkg::ADDR_W-1:0]     o_mr1         // mode register 1 copy
);
  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // cke is the only command pin that may arrive with no clock around it
  logic [2:0] cke_sync;
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_sync <= 3'h0;
    end else begin
      cke_sync <= {cke_sync[1:0], i_cke};
    end
  end

  // self-refresh exit: the cke rise itself sets the wake flag, no clock needed
  logic sref_arm_n;
  logic sref_flag;
  logic sref_q1;
  logic sref_q2;
  logic sref_q3;
  // flag is held clear outside self-refresh so a stale rise never wakes us
  always_ff @(posedge i_cke or negedge sref_arm_n) begin
    if (!sref_arm_n) begin
      sref_flag <= 1'b0;
    end else begin
      sref_flag <= 1'b1;
    end
  end
  // the wake flag crosses into the core clock through three flops
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sref_q1 <= 1'b0;
      sref_q2 <= 1'b0;
      sref_q3 <= 1'b0;
    end else begin
      sref_q1 <= sref_flag;
      sref_q2 <= sref_q1;
      sref_q3 <= sref_q2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode
  dcp_pkg::dcp_cmd_t cmd;
  dcp_cmd_decode u_dec (
    .i_cs_n  (i_cs_n),
    .i_ras_n (i_ras_n),
    .i_cas_n (i_cas_n),
    .i_we_n  (i_we_n),
    .o_cmd   (cmd)
  );

  function automatic logic is_noop(input dcp_pkg::dcp_cmd_t c);
    is_noop = (c == dcp_pkg::DCP_CMD_NOP) || (c == dcp_pkg::DCP_CMD_DES);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    dcp_pkg::dcp_state_t            st;
    logic [dcp_pkg::NBANK-1:0]      open;
    logic [2:0]                     burst;
    logic                           dll_off;
    logic                           cmd_valid;
    logic                           ref_d;
    logic [3:0]                     cmd;
    logic [dcp_pkg::BA_W-1:0]       cmd_ba;
    logic [dcp_pkg::ADDR_W-1:0]     mr1;
  } dcp_core_t;
  dcp_core_t r;
  dcp_core_t next_r;

  logic cke_prev;
  logic cke_now;
  logic cke_fall;
  logic cke_rise;
  logic rd_go;
  assign cke_prev = cke_sync[2];
  assign cke_now  = cke_sync[1];
  assign cke_fall = cke_prev & ~cke_now;
  assign cke_rise = ~cke_prev & cke_now;
  assign rd_go    = next_r.cmd_valid && (next_r.cmd == dcp_pkg::DCP_CMD_RD);
  assign sref_arm_n = rst_n && (r.st == dcp_pkg::DCP_ST_SREF);

  // bank address is one-hot decoded for activate and precharge
  function automatic logic [dcp_pkg::NBANK-1:0] bank_bit(input logic [dcp_pkg::BA_W-1:0] b);
    bank_bit = '0;
    bank_bit[b] = 1'b1;
  endfunction

  always_comb begin
    next_r = r;
    next_r.cmd_valid = 1'b0;
    // the synchronised cke fall shows one edge after the refresh it came with
    next_r.ref_d = r.cmd_valid && (r.cmd == dcp_pkg::DCP_CMD_REF);
    if (r.burst != 3'h0) begin
      next_r.burst = r.burst - 3'h1;
    end
    unique case (r.st)
      dcp_pkg::DCP_ST_IDLE, dcp_pkg::DCP_ST_ACTIVE: begin
        if (cke_fall) begin
          // refresh with cke falling from idle sleeps; else power-down
          if (r.ref_d && r.st == dcp_pkg::DCP_ST_IDLE && r.burst == 3'h0) begin
            next_r.st = dcp_pkg::DCP_ST_SREF;
          end else if (r.open == '0) begin
            next_r.st = dcp_pkg::DCP_ST_PPD;
          end else begin
            next_r.st = dcp_pkg::DCP_ST_APD;
          end
        end else if (cke_now && !is_noop(cmd)) begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd       = cmd;
          next_r.cmd_ba    = i_ba;
          unique case (cmd)
            dcp_pkg::DCP_CMD_ACT: next_r.open = r.open | bank_bit(i_ba);
            dcp_pkg::DCP_CMD_PRE: next_r.open = i_addr[dcp_pkg::AP_BIT] ? '0 : (r.open & ~bank_bit(i_ba));
            dcp_pkg::DCP_CMD_RD, dcp_pkg::DCP_CMD_WR: begin
              next_r.burst = dcp_pkg::BURST_CLKS;
              if (i_addr[dcp_pkg::AP_BIT]) begin
                next_r.open = r.open & ~bank_bit(i_ba);
              end
            end
            dcp_pkg::DCP_CMD_MRS: begin
              if (i_ba == dcp_pkg::MR1_SEL) begin
                next_r.mr1     = i_addr;
                next_r.dll_off = i_addr[dcp_pkg::DLL_OFF_BIT];
              end
            end
            default: begin
            end
          endcase
        end
        if (next_r.st == dcp_pkg::DCP_ST_IDLE || next_r.st == dcp_pkg::DCP_ST_ACTIVE) begin
          next_r.st = (next_r.open == '0) ? dcp_pkg::DCP_ST_IDLE : dcp_pkg::DCP_ST_ACTIVE;
        end
      end
      // address and command ignored while asleep; no refresh in power-down
      dcp_pkg::DCP_ST_APD, dcp_pkg::DCP_ST_PPD: begin
        if (cke_rise) begin
          next_r.st = (r.open == '0) ? dcp_pkg::DCP_ST_IDLE : dcp_pkg::DCP_ST_ACTIVE;
        end
      end
      dcp_pkg::DCP_ST_SREF: begin
        if (sref_q2 && sref_q3) begin
          next_r.st = dcp_pkg::DCP_ST_IDLE;
        end
      end
      default: next_r.st = dcp_pkg::DCP_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dll-off read timing: window opens one cycle earlier than al+cl
  logic [4:0] rd_lat;
  assign rd_lat = r.dll_off ? (i_al + i_cl - dcp_pkg::LAT_ONE) : (i_al + i_cl);

  dcp_rd_window u_rw (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_rd       (rd_go),
    .i_lat      (rd_lat),
    .o_open     (o_rd_window)
  );

  assign o_state     = r.st;
  assign o_bank_open = r.open;
  assign o_burst     = (r.burst != 3'h0);
  assign o_idle      = (r.st == dcp_pkg::DCP_ST_IDLE) && (r.burst == 3'h0) && cke_now;
  assign o_dll_off   = r.dll_off;
  // only one latency pair is legal once the dll is off
  assign o_lat_ok    = !r.dll_off || (i_cl == dcp_pkg::DLL_OFF_CL && i_cwl == dcp_pkg::DLL_OFF_CWL);
  // termination is a side path: it never feeds the state above
  assign o_odt_en    = i_odt && (r.st != dcp_pkg::DCP_ST_SREF);
  assign o_cmd_valid = r.cmd_valid;
  assign o_cmd       = r.cmd;
  assign o_cmd_ba    = r.cmd_ba;
  assign o_mr1       = r.mr1;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sref_entry_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (r.st != dcp_pkg::DCP_ST_SREF && next_r.st == dcp_pkg::DCP_ST_SREF) |-> (r.open == '0 && r.burst == 3'h0))
    else $error("self-refresh entered with banks open or burst running");
  pd_entry_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (r.st == dcp_pkg::DCP_ST_ACTIVE && cke_fall) |=> (r.st == dcp_pkg::DCP_ST_APD))
    else $error("active power-down not entered on cke fall");
  pd_hold_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (r.st == dcp_pkg::DCP_ST_PPD && !cke_rise) |=> (r.st == dcp_pkg::DCP_ST_PPD && $stable(r.open)))
    else $error("power-down left without cke rise");
  noop_quiet_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (is_noop(cmd) && r.burst == 3'h2) |=> (!r.cmd_valid && r.burst == 3'h1))
    else $error("nop disturbed state or burst");
  burst_len_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (r.cmd_valid && (r.cmd == dcp_pkg::DCP_CMD_RD)) |-> o_burst [*4] ##1 !o_burst)
    else $error("burst length wrong");
  dll_bit_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (r.cmd_valid && r.cmd == dcp_pkg::DCP_CMD_MRS && r.cmd_ba == dcp_pkg::MR1_SEL) |-> (r.dll_off == r.mr1[0]))
    else $error("dll state does not follow mode register 1 bit 0");
  odt_sref_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (r.st == dcp_pkg::DCP_ST_SREF) |-> !o_odt_en)
    else $error("termination on in self-refresh");
  rd_dlloff_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (rd_go && r.dll_off && i_al == 5'h0 && i_cl == 5'h6 && $stable(i_cl)) |-> ##5 o_rd_window)
    else $error("dll-off read window not at al+cl-1");
  idle_def_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    o_idle |-> (r.open == '0 && !o_burst))
    else $error("idle with bank open or burst");
endmodule
`default_nettype wire

/* File: rtl/dcp_cmd_decode.sv */
// command decoder: combinational decode of chip select and the three strobes, no cke
`timescale 1ns/1ps
`default_nettype none
module dcp_cmd_decode (
  input  wire logic              i_cs_n,    // chip select
  input  wire logic              i_ras_n,   // row strobe
  input  wire logic              i_cas_n,   // column strobe
  input  wire logic              i_we_n,    // write enable
  output var dcp_pkg::dcp_cmd_t  o_cmd      // decoded command
);
  always_comb begin
    if (i_cs_n) begin
      o_cmd = dcp_pkg::DCP_CMD_DES;
    end else begin
      unique case ({i_ras_n, i_cas_n, i_we_n})
        3'h0: o_cmd = dcp_pkg::DCP_CMD_MRS;
        3'h1: o_cmd = dcp_pkg::DCP_CMD_REF;
        3'h2: o_cmd = dcp_pkg::DCP_CMD_PRE;
        3'h3: o_cmd = dcp_pkg::DCP_CMD_ACT;
        3'h4: o_cmd = dcp_pkg::DCP_CMD_WR;
        3'h5: o_cmd = dcp_pkg::DCP_CMD_RD;
        3'h6: o_cmd = dcp_pkg::DCP_CMD_ZQ;
        default: o_cmd = dcp_pkg::DCP_CMD_NOP;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dcp_pkg.sv */
// constants and types for the ddr3 command and cke state logic
package dcp_pkg;
  localparam int unsigned BA_W     = 3;
  localparam int unsigned ADDR_W   = 15;
  localparam int unsigned NBANK    = 8;
  localparam int unsigned LAT_W    = 5;
  localparam int unsigned BURST_W  = 3;
  // bursts are eight beats on four clocks; bc4 still occupies the slot
  localparam logic [2:0]  BURST_CLKS = 3'h4;
  localparam logic [3:0]  CKE_MIN    = 4'h3;   // cke pulse, controller side
  localparam int unsigned DLL_OFF_BIT = 0;      // mode register 1 bit a0
  localparam int unsigned AP_BIT      = 10;     // a10 selects all banks / auto precharge
  localparam logic [2:0]  MR1_SEL     = 3'h1;
  localparam logic [4:0]  DLL_OFF_CL  = 5'h6;
  localparam logic [4:0]  DLL_OFF_CWL = 5'h6;
  localparam logic [4:0]  LAT_ONE     = 5'h1;
  localparam logic [4:0]  DEF_CL      = 5'h6;
  localparam logic [4:0]  DEF_AL      = 5'h0;

  // decoded command: {ras_n,cas_n,we_n} with cs_n low; deselect is 4'h8, with cs_n high
  typedef enum logic [3:0] {
    DCP_CMD_MRS = 4'h0,
    DCP_CMD_REF = 4'h1,
    DCP_CMD_PRE = 4'h2,
    DCP_CMD_ACT = 4'h3,
    DCP_CMD_WR  = 4'h4,
    DCP_CMD_RD  = 4'h5,
    DCP_CMD_ZQ  = 4'h6,
    DCP_CMD_NOP = 4'h7,
    DCP_CMD_DES = 4'h8
  } dcp_cmd_t;

  // gray codes along idle -> power-down -> exit; idle -> self-refresh flips two bits
  typedef enum logic [2:0] {
    DCP_ST_IDLE   = 3'h0,
    DCP_ST_ACTIVE = 3'h1,
    DCP_ST_APD    = 3'h3,
    DCP_ST_PPD    = 3'h2,
    DCP_ST_SREF   = 3'h6
  } dcp_state_t;
endpackage

/* File: rtl/dcp_rd_window.sv */
// read strobe window timer: flags the edge the read strobe window opens
`timescale 1ns/1ps
`default_nettype none
module dcp_rd_window (
  input  wire logic        i_core_clk,  // core clock
  input  wire logic        i_rst_n,     // synchronised reset
  input  wire logic        i_rd,        // read registered this edge
  input  wire logic [4:0]  i_lat,       // cycles from read to window
  output logic             o_open       // window opens at this edge
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       busy;
    logic       open;
  } dcp_rw_t;
  dcp_rw_t r;
  dcp_rw_t next_r;

  // one read in flight; bursts are spaced wider than the latency allows
  always_comb begin
    next_r = r;
    next_r.open = 1'b0;
    if (i_rd) begin
      next_r.busy = (i_lat > dcp_pkg::LAT_ONE);
      next_r.cnt  = i_lat - dcp_pkg::LAT_ONE;
      next_r.open = (i_lat <= dcp_pkg::LAT_ONE);
    end else if (r.busy) begin
      next_r.cnt = r.cnt - dcp_pkg::LAT_ONE;
      if (r.cnt == dcp_pkg::LAT_ONE) begin
        next_r.busy = 1'b0;
        next_r.open = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign o_open = r.open;
endmodule
`default_nettype wire

/* File: verif/dcp_cke_state_tb.sv */
// self-checking bench for the ddr3 command and cke power state logic
`timescale 1ns/1ps
`default_nettype none
module dcp_cke_state_tb;
  logic                       clk, arst_n, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [dcp_pkg::BA_W-1:0]   ba, cmd_ba;
  logic [dcp_pkg::ADDR_W-1:0] addr, mr1;
  logic [4:0]                 cl, cwl, al;
  logic [2:0]                 state;
  logic [dcp_pkg::NBANK-1:0]  bank_open;
  logic                       burst, idle, dll_off, lat_ok, odt_en, rd_win, cmd_v;
  logic [3:0]                 cmd, flags;
  int                         checks, mismatches;
  assign flags = {cmd_v, idle, dll_off, lat_ok};
  dcp_ctl_model ctl (.i_core_clk(clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
  dcp_cke_state uut (.i_core_clk(clk), .i_arst_n(arst_n), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_odt(odt),
    .i_cl(cl), .i_cwl(cwl), .i_al(al), .o_state(state), .o_bank_open(bank_open),
    .o_burst(burst), .o_idle(idle), .o_dll_off(dll_off), .o_lat_ok(lat_ok), .o_odt_en(odt_en),
    .o_rd_window(rd_win), .o_cmd_valid(cmd_v), .o_cmd(cmd), .o_cmd_ba(cmd_ba), .o_mr1(mr1));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;  // one fixed rate, also used in dll-off mode
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // cke passes a synchroniser, so state moves a few clocks after the pin
  task automatic wait_state(input logic [2:0] s, input string msg);
    for (int i = 0; i < 12 && state !== s; i++) tick;
    chk(state === s, msg);
  endtask
  task automatic wait_flag(input int b, input logic v);
    #1;
    for (int i = 0; i < 6 && flags[b] !== v; i++) tick;
  endtask
  task automatic quiet(input int n, output int seen);
    seen = 0;
    repeat (n) begin
      tick;
      seen += (cmd_v === 1'b1);
    end
  endtask
  // one read or write, then deselects with moving pins while the burst runs
  task automatic t_burst(input logic [3:0] c, input logic [2:0] b, input int win);
    int n, first, pulses;
    first = -1;
    n = 0;
    pulses = 0;
    ctl.cmd(c, b, 15'h0000, 1'b1);
    #1;
    for (int i = 0; i < 12; i++) begin
      if (rd_win === 1'b1 && first < 0) first = i;
      n += (burst === 1'b1);
      pulses += (cmd_v === 1'b1);
      tick;
    end
    chk(cmd === c && cmd_ba === b, "read or write decode");
    chk(n == dcp_pkg::BURST_CLKS && pulses == 1, "burst length or extra command");
    chk(first == win, "read strobe window edge");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_cmds;
    ctl.cmd(dcp_pkg::DCP_CMD_ACT, 3'h3, 15'h0123, 1'b1);
    wait_flag(3, 1'b1);
    chk(cmd === dcp_pkg::DCP_CMD_ACT && cmd_ba === 3'h3, "activate decode");
    tick;
    chk(bank_open === 8'h08 && state === 3'h1 && idle === 1'b0, "bank 3 open");
    t_burst(dcp_pkg::DCP_CMD_WR, 3'h3, -1);
    t_burst(dcp_pkg::DCP_CMD_RD, 3'h3, 5);
  endtask
  task automatic t_pdown;
    int n;
    ctl.cke_to(1'b0);
    wait_state(3'h3, "active power-down");
    fork
      ctl.cmd(dcp_pkg::DCP_CMD_RD, 3'h3, 15'h7FFF, 1'b0);
      quiet(8, n);
    join
    chk(n == 0 && burst === 1'b0 && state === 3'h3, "command taken in power-down");
    ctl.cke_to(1'b1);
    wait_state(3'h1, "active power-down exit");
    ctl.cmd(dcp_pkg::DCP_CMD_PRE, 3'h0, 15'h0400, 1'b1);
    wait_flag(2, 1'b1);
    chk(bank_open === 8'h00 && idle === 1'b1, "precharge all");
    ctl.cke_to(1'b0);
    wait_state(3'h2, "precharge power-down");
    chk(idle === 1'b0, "idle with cke low");
    ctl.cke_to(1'b1);
    wait_state(3'h0, "precharge power-down exit");
  endtask
  task automatic t_sref;
    int n;
    @(posedge clk);
    odt <= 1'b1;
    quiet(2, n);
    chk(odt_en === 1'b1 && state === 3'h0, "termination in idle");
    ctl.cmd(dcp_pkg::DCP_CMD_REF, 3'h0, 15'h0000, 1'b0);
    wait_state(3'h6, "self-refresh entry");
    quiet(4, n);
    chk(odt_en === 1'b0 && n == 0, "termination in self-refresh");
    ctl.cke_to(1'b1);
    wait_state(3'h0, "self-refresh exit");
    chk(odt_en === 1'b1, "termination after exit");
    @(posedge clk);
    odt <= 1'b0;
  endtask
  task automatic t_dll;
    ctl.cmd(dcp_pkg::DCP_CMD_MRS, 3'h0, 15'h0001, 1'b1);
    wait_flag(3, 1'b1);
    tick;
    chk(dll_off === 1'b0 && cmd_ba === 3'h0, "other mode register write");
    ctl.cmd(dcp_pkg::DCP_CMD_MRS, dcp_pkg::MR1_SEL, 15'h0001, 1'b1);
    wait_flag(1, 1'b1);
    chk(dll_off === 1'b1 && mr1 === 15'h0001, "dll off");
    chk(lat_ok === 1'b1, "latency 6 and 6 refused");
    @(posedge clk);
    cl <= 5'h7;
    tick;
    chk(lat_ok === 1'b0, "latency 7 accepted");
    @(posedge clk);
    cl <= 5'h6;
    ctl.cmd(dcp_pkg::DCP_CMD_ACT, 3'h0, 15'h0000, 1'b1);
    t_burst(dcp_pkg::DCP_CMD_RD, 3'h0, 4);
    @(posedge clk);
    al <= 5'h1;
    t_burst(dcp_pkg::DCP_CMD_RD, 3'h0, 5);
    @(posedge clk);
    al <= 5'h0;
    ctl.cmd(dcp_pkg::DCP_CMD_MRS, dcp_pkg::MR1_SEL, 15'h0000, 1'b1);
    wait_flag(1, 1'b0);
    chk(dll_off === 1'b0, "dll back on");
    t_burst(dcp_pkg::DCP_CMD_RD, 3'h0, 5);
  endtask
  // reset lands between edges of the internal logic, so no clock is needed to clear
  task automatic t_areset;
    ctl.cmd(dcp_pkg::DCP_CMD_ACT, 3'h5, 15'h0000, 1'b1);
    wait_flag(3, 1'b1);
    tick;
    chk(bank_open === 8'h21, "banks 0 and 5 open");
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    chk(bank_open === 8'h00 && state === 3'h0 && cmd_v === 1'b0, "async reset");
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) tick;
    chk(idle === 1'b1 && dll_off === 1'b0, "idle after second reset");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    odt = 1'b0;
    cl = 5'h6;
    cwl = 5'h6;
    al = 5'h0;
    checks = 0;
    mismatches = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) tick;
    chk(state === 3'h0 && bank_open === 8'h00 && burst === 1'b0, "reset state");
    chk(idle === 1'b1 && dll_off === 1'b0, "idle after reset");
    t_cmds;
    t_pdown;
    t_sref;
    t_dll;
    t_areset;
    end_of_test;
  end
  // the run needs some 190 clocks; a hang is cut off well beyond that
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire

/* File: verif/dcp_ctl_model.sv */
// controller-side model driving clock enable, command and address pins
`timescale 1ns/1ps
`default_nettype none
module dcp_ctl_model #(
  parameter int unsigned XS_CLKS = 8  // exit delay after self-refresh, in clocks
) (
  input  wire logic                      i_core_clk, // core clock
  output var logic                       o_cke,      // clock enable
  output var logic                       o_cs_n,     // chip select, active low
  output var logic                       o_ras_n,    // row strobe, active low
  output var logic                       o_cas_n,    // column strobe, active low
  output var logic                       o_we_n,     // write enable, active low
  output var logic [dcp_pkg::BA_W-1:0]   o_ba,       // bank address
  output var logic [dcp_pkg::ADDR_W-1:0] o_addr      // address
);
  logic rel;
  initial begin
    rel = 1'b1;
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n, o_ba, o_addr} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // released pins change every cycle so a stale level is never read as a command
  // off the sampling edge, so it never races a command driven at the rising edge
  always @(negedge i_core_clk) begin
    if (rel) begin
      {o_ras_n, o_cas_n, o_we_n, o_ba, o_addr} <= ~{o_ras_n, o_cas_n, o_we_n, o_ba, o_addr};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // code bit 3 is chip select, bits 2:0 the three strobes; only table encodings
  task automatic cmd(input logic [3:0] c, input logic [dcp_pkg::BA_W-1:0] b,
                     input logic [dcp_pkg::ADDR_W-1:0] a, input logic ck);
    @(posedge i_core_clk);
    rel = 1'b0;
    o_cs_n <= c[3];
    {o_ras_n, o_cas_n, o_we_n} <= c[2:0];
    o_ba <= b;
    o_addr <= a;
    o_cke <= ck;
    @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    rel = 1'b1;
    if (!ck) begin
      repeat (dcp_pkg::CKE_MIN) @(posedge i_core_clk);
    end
  endtask
  task automatic cke_to(input logic v);
    @(posedge i_core_clk);
    o_cke <= v;
    repeat (dcp_pkg::CKE_MIN) @(posedge i_core_clk);
    if (v) begin
      repeat (XS_CLKS) @(posedge i_core_clk);
    end
  endtask
endmodule
`default_nettype wire
